// ===== hdl/rpp_port_guard.sv
`timescale 1ns/1ns
`default_nettype none
module rpp_port_guard #(
  parameter int N          = rpp_pkg::NPORTS,
  parameter int JAB_CYCLES = rpp_pkg::JAB_CYC,
  parameter int PART_MAX   = rpp_pkg::PART_MAX_CYC,
  parameter int MAIN_PORT  = 0,
  parameter int STBY_PORT  = 1
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // segment side, one bit per port
  input  wire logic [N-1:0]      rx_crs_i,
  input  wire logic [N-1:0]      rx_dat_i,
  input  wire logic [N-1:0]      rx_good_i,
  input  wire logic [N-1:0]      link_ok_i,
  output logic      [N-1:0]      tx_en_o,
  output logic      [N-1:0]      tx_dat_o,
  output logic      [N-1:0]      xover_o,
  // backplane side
  input  wire rpp_pkg::rpp_bp_in_t  bp_i,
  output rpp_pkg::rpp_bp_out_t      bp_o,
  // straps read once after reset
  input  wire logic              strap_iso_i,
  input  wire logic              strap_sec_i,
  input  wire logic [1:0]        strap_bus_i,
  input  wire logic [N-1:0]      strap_pwrdis_i,
  input  wire logic [N-1:0]      strap_xover_i,
  // status
  output logic                   power_indicator_o
);
  localparam int PW = (N > 1) ? $clog2(N) : 1;
  localparam int JW = $clog2(JAB_CYCLES+1);
  localparam int CW = $clog2(PART_MAX+2);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                ld;      // straps taken
    logic                iso;     // isolated from backplane
    logic                sec;     // secure delivery on
    logic                res;     // resilient pair armed
    logic [1:0]          bus;     // backplane bus code
    logic [N-1:0]        en;      // port enabled
    logic [N-1:0]        test;    // port sends test pattern
    logic [N-1:0]        xo;      // crossover wiring
    logic [N-1:0]        part;    // port partitioned
    logic [N-1:0]        intr;    // intruder seen
    logic [N-1:0]        jab;     // port jabbering
    logic [N-1:0]        cpk;     // collision in current activity
    logic [N-1:0]        inv;     // ports in current collision
    logic [N-1:0]        prv_crs; // last carrier, for end detect
    logic [N-1:0]        tx_en;
    logic [N-1:0]        tx_dat;
    logic [N-1:0][5:0]   ccnt;    // consecutive collisions
    logic [N-1:0][JW-1:0] jcnt;   // receive length
    logic [N-1:0][47:0]  addr;    // station address per port
    logic                incol;   // collision in progress
    logic                jam;     // jamming this cycle
    logic                srcv;    // a local port is the source
    logic                bp_en;
    logic                bp_dat;
    logic                sfd;     // preamble done
    logic                prev;    // last preamble bit
    logic [PW-1:0]       src;     // local source port
    logic [CW-1:0]       clen;    // collision length
    logic [7:0]          ext;     // jam cycles left
    logic [6:0]          bcnt;    // header bits taken
    logic [47:0]         sh;      // header shifter
    logic [47:0]         dst;     // destination of this frame
    logic [14:0]         lfsr;    // scrambler
    logic [31:0]         frames;
    logic [31:0]         colls;
    logic [31:0]         dat;     // read data
    logic                ack;
  } rpp_state_t;

  rpp_state_t st;
  rpp_state_t nx;

  // comb helpers
  logic [N-1:0]  act;   // forwardable receivers
  logic [PW-1:0] s;     // chosen local source
  logic          sv;    // local source valid
  logic          bpa;   // backplane carrier counted
  logic          col;   // collision now
  logic          d;     // repeated data bit
  logic          busy;  // something being repeated
  logic          wr;    // write taken this edge
  logic [31:0]   rd;    // current register value
  logic [31:0]   w;     // merged write value
  logic [7:0]    aoff;  // offset into address block
  logic [PW-1:0] idx;   // address block port
  logic          aok;   // offset lands on a port
  logic [47:0]   srca;  // completed source address
  logic          scr;   // scramble toward this port
  int            nact;  // number of active receivers

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge for wishbone writes
  function automatic logic [31:0] wmask(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // bus code to one-hot; spare code falls back to bus one
  function automatic logic [2:0] bus_dec(input logic [1:0] b);
    logic [2:0] r;
    r = 3'h1;
    if (b == 2'h1) begin
      r = 3'h2;
    end else if (b == 2'h2) begin
      r = 3'h4;
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx   = st;
    act  = '0;
    s    = '0;
    sv   = 1'b0;
    nact = 0;
    rd   = '0;
    scr  = 1'b0;
    // straps, once after reset
    if (!st.ld) begin
      nx.ld  = 1'b1;
      nx.iso = strap_iso_i;
      nx.sec = strap_sec_i;
      nx.bus = strap_bus_i;
      nx.en  = ~strap_pwrdis_i;
      nx.xo  = strap_xover_i;
    end
    // register read, always served even when isolated
    aoff = wb_adr_i - rpp_pkg::A_ADDR;
    idx  = PW'(aoff[7:3]);
    aok  = (wb_adr_i >= rpp_pkg::A_ADDR) && (int'(aoff[7:3]) < N);
    case (wb_adr_i)
      rpp_pkg::A_CTRL: begin
        rd[rpp_pkg::C_ISO]      = st.iso;
        rd[rpp_pkg::C_SEC]      = st.sec;
        rd[rpp_pkg::C_BUS +: 2] = st.bus;
        rd[rpp_pkg::C_RES]      = st.res;
      end
      rpp_pkg::A_EN:     rd = 32'(st.en);
      rpp_pkg::A_TEST:   rd = 32'(st.test);
      rpp_pkg::A_XOVER:  rd = 32'(st.xo);
      rpp_pkg::A_STAT: begin
        rd[N-1:0] = st.part;
        rd[rpp_pkg::STAT_JAB +: N] = st.jab;
      end
      rpp_pkg::A_INTR:   rd = 32'(st.intr);
      rpp_pkg::A_FRAMES: rd = st.frames;
      rpp_pkg::A_COLLS:  rd = st.colls;
      default: begin
        if (aok && !aoff[2]) begin
          rd = st.addr[idx][31:0];
        end else if (aok) begin
          rd = {16'h0000, st.addr[idx][47:32]};
        end
      end
    endcase
    // answer one cycle after the strobe, data from the flop
    nx.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_cyc_i & wb_stb_i & ~st.ack) begin
      nx.dat = rd;
    end
    // write takes effect at the acknowledging edge
    wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;
    w  = wmask(rd, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i)
        rpp_pkg::A_CTRL: begin
          nx.iso = w[rpp_pkg::C_ISO];
          nx.sec = w[rpp_pkg::C_SEC];
          nx.bus = w[rpp_pkg::C_BUS +: 2];
          nx.res = w[rpp_pkg::C_RES];
        end
        rpp_pkg::A_EN:    nx.en   = w[N-1:0];
        rpp_pkg::A_TEST:  nx.test = w[N-1:0];
        rpp_pkg::A_XOVER: nx.xo   = w[N-1:0];
        rpp_pkg::A_INTR:  nx.intr = st.intr & ~w[N-1:0];
        default: begin
          if (aok && !aoff[2]) begin
            nx.addr[idx][31:0] = w;
          end else if (aok) begin
            nx.addr[idx][47:32] = w[15:0];
          end
        end
      endcase
    end
    // pick receivers allowed to feed the network
    for (int i = 0; i < N; i++) begin
      act[i] = rx_crs_i[i] & st.en[i] & ~st.part[i]
             & ~st.jab[i] & ~st.test[i];
      if (act[i]) begin
        nact++;
      end
    end
    // lowest numbered active port wins
    for (int i = N-1; i >= 0; i--) begin
      if (act[i]) begin
        s  = PW'(i);
        sv = 1'b1;
      end
    end
    bpa  = bp_i.crs & ~st.iso;
    col  = ((nact + int'(bpa)) > 1) || (bp_i.col && !st.iso);
    d    = sv ? rx_dat_i[s] : bp_i.dat;
    busy = sv | bpa;
    // jabber watch per receiver
    for (int i = 0; i < N; i++) begin
      if (!rx_crs_i[i]) begin
        nx.jcnt[i] = '0;
        nx.jab[i]  = 1'b0;
      end else if (st.jcnt[i] == JW'(JAB_CYCLES)) begin
        nx.jab[i]  = 1'b1;
      end else begin
        nx.jcnt[i] = st.jcnt[i] + JW'(1);
      end
    end
    // collision start, run and end
    nx.incol = col;
    if (col && !st.incol) begin
      nx.ext   = 8'(rpp_pkg::JAM_CYC);
      nx.colls = st.colls + 32'h1;
      nx.clen  = CW'(1);
      nx.inv   = act;
      for (int i = 0; i < N; i++) begin
        if (act[i]) begin
          nx.cpk[i] = 1'b1;
          if (st.ccnt[i] < 6'(rpp_pkg::CONS_COLL)) begin
            nx.ccnt[i] = st.ccnt[i] + 6'h1;
          end
          if (st.ccnt[i] >= 6'(rpp_pkg::CONS_COLL - 1)) begin
            nx.part[i] = 1'b1;
          end
        end
      end
    end else if (col) begin
      if (st.clen <= CW'(PART_MAX)) begin
        nx.clen = st.clen + CW'(1);
      end
      nx.inv = st.inv | act;
      nx.cpk = st.cpk | act;
    end else if (st.incol) begin
      // long single collision, judged once it ends
      if (st.clen >= CW'(rpp_pkg::PART_MIN_CYC) &&
          st.clen <= CW'(PART_MAX)) begin
        nx.part = st.part | st.inv;
      end
    end
    if (!col && st.ext != 8'h00) begin
      nx.ext = st.ext - 8'h01;
    end
    // end of a port's activity
    for (int i = 0; i < N; i++) begin
      if (st.prv_crs[i] && !rx_crs_i[i]) begin
        if (!st.cpk[i]) begin
          nx.ccnt[i] = 6'h00;
        end
        nx.cpk[i] = 1'b0;
      end
    end
    nx.prv_crs = rx_crs_i;
    // reconnect last so a good packet always wins
    for (int i = 0; i < N; i++) begin
      if (rx_good_i[i] && st.part[i]) begin
        nx.part[i] = 1'b0;
        nx.ccnt[i] = 6'h00;
      end
    end
    // header parser on the repeated stream
    srca = {d, st.sh[47:1]};
    if (!busy) begin
      nx.sfd  = 1'b0;
      nx.bcnt = '0;
      nx.prev = 1'b0;
    end else if (!st.sfd) begin
      nx.sfd  = st.prev & d;
      nx.prev = d;
    end else if (st.bcnt < 7'(rpp_pkg::SRC_END)) begin
      nx.sh   = srca;
      nx.bcnt = st.bcnt + 7'h01;
      if (st.bcnt == 7'(rpp_pkg::DST_BITS - 1)) begin
        nx.dst = srca;
      end
      if (st.bcnt == 7'(rpp_pkg::SRC_END - 1) && sv && st.sec &&
          srca != st.addr[s]) begin
        nx.intr[s] = 1'b1;
      end
    end
    nx.lfsr = {st.lfsr[13:0], st.lfsr[14] ^ st.lfsr[13]};
    // transmit side, one register stage for every path
    nx.jam = col | (st.ext != 8'h00);
    for (int p = 0; p < N; p++) begin
      scr = st.sec && st.bcnt >= 7'(rpp_pkg::DST_BITS) && !st.dst[0]
            && st.dst != st.addr[p];
      nx.tx_en[p]  = 1'b0;
      nx.tx_dat[p] = 1'b0;
      if (st.test[p]) begin
        nx.tx_en[p]  = 1'b1;
        nx.tx_dat[p] = st.lfsr[0];
      end else if (st.en[p] && nx.jam) begin
        nx.tx_en[p]  = 1'b1;
        nx.tx_dat[p] = ~st.tx_dat[p];
      end else if (st.en[p] && busy && !(sv && s == PW'(p))) begin
        nx.tx_en[p]  = 1'b1;
        nx.tx_dat[p] = scr ? st.lfsr[0] : d;
      end
    end
    nx.bp_en  = ~st.iso & (sv | (nx.jam & (nact > 0)));
    nx.bp_dat = nx.jam ? ~st.bp_dat : d;
    // frame counter on end of local source
    if (st.srcv && !sv) begin
      nx.frames = st.frames + 32'h1;
    end
    nx.srcv = sv;
    nx.src  = s;
    // main port lost: hand over to standby
    if (st.res && !link_ok_i[MAIN_PORT] && st.en[MAIN_PORT]) begin
      nx.en[MAIN_PORT] = 1'b0;
      nx.en[STBY_PORT] = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= '0;
      st.lfsr <= rpp_pkg::LFSR_SEED;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o          = st.dat;
  assign wb_ack_o          = st.ack;
  assign tx_en_o           = st.tx_en;
  assign tx_dat_o          = st.tx_dat;
  assign xover_o           = st.xo;
  assign power_indicator_o = st.ld;
  // isolated module drives no bus at all
  assign bp_o = {(st.iso ? 3'h0 : bus_dec(st.bus)), st.bp_en, st.bp_dat};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_cons_part: assert property (
    st.ccnt[0] >= 6'(rpp_pkg::CONS_COLL) |-> st.part[0])
    else $error("collision limit reached without partition");
  a_part_fwd: assert property (
    st.srcv && st.src == '0 |-> !$past(st.part[0]))
    else $error("partitioned port was forwarded");
  a_good_reconn: assert property (
    st.part[0] && rx_good_i[0] |=> !st.part[0])
    else $error("good packet did not reconnect");
  a_sec_pass: assert property (
    st.srcv && st.src == '0 && !st.jam && st.tx_en[1] &&
    !$past(st.sec) && !$past(st.test[1])
    |-> st.tx_dat[1] == $past(rx_dat_i[0]))
    else $error("repeated bit differs from source");
  a_frag_ext: assert property (
    $rose(st.incol) |-> st.ext == 8'(rpp_pkg::JAM_CYC))
    else $error("jam extension not loaded");
  a_jab_cut: assert property (
    $rose(st.jab[0]) |-> st.jcnt[0] == JW'(JAB_CYCLES))
    else $error("jabber cut at wrong length");
  a_iso_quiet: assert property (
    st.iso && $past(st.iso) |-> !st.bp_en)
    else $error("isolated module drove backplane");
  a_pwr_dis: assert property (
    $rose(st.ld) |-> st.en == ~$past(strap_pwrdis_i))
    else $error("power-up enables do not follow straps");
  a_same_lat: assert property (
    st.srcv && st.src == '0 && !st.jam && $past(st.en[1]) &&
    !$past(st.test[1]) |-> st.tx_en[1])
    else $error("repeat delayed on a port");
  a_res_swap: assert property (
    st.res && !link_ok_i[MAIN_PORT] && st.en[MAIN_PORT]
    |=> !st.en[MAIN_PORT] && st.en[STBY_PORT])
    else $error("standby did not take over");
  a_bus_one: assert property (
    !st.iso |-> $onehot({bp_o.backplane_bus_three,
                         bp_o.backplane_bus_two,
                         bp_o.backplane_bus_one}))
    else $error("backplane bus select not one-hot");

  c_partition: cover property ($rose(st.part[0]));
  c_scramble:  cover property (st.sec && st.bcnt == 7'(rpp_pkg::SRC_END));
  c_swap:      cover property ($fell(st.en[MAIN_PORT]) && st.res);
  c_intruder:  cover property ($rose(st.intr[0]));
endmodule
`default_nettype wire

// ===== pkg/rpp_pkg.sv
`default_nettype none
package rpp_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS        = 100;   // 10 MHz system clock
  localparam int BIT_NS        = 100;   // one bit time on the segment
  localparam int NPORTS        = 12;    // ports per module
  localparam int CONS_COLL     = 32;    // consecutive collision limit
  localparam int PART_MIN_BITS = 1000;  // long collision, lower bound
  localparam int PART_MAX_BITS = 30000; // long collision, upper bound
  localparam int PART_MIN_CYC  = (PART_MIN_BITS*BIT_NS+CLK_NS-1)/CLK_NS;
  localparam int PART_MAX_CYC  = PART_MAX_BITS*BIT_NS/CLK_NS;
  localparam int JAB_US        = 5000;  // receive time before cut-off
  localparam int JAB_CYC       = JAB_US*1000/CLK_NS;
  localparam int JAM_BITS      = 96;    // least jam after a collision
  localparam int JAM_CYC       = (JAM_BITS*BIT_NS+CLK_NS-1)/CLK_NS;
  localparam int DST_BITS      = 48;    // destination address length
  localparam int SRC_END       = 96;    // last bit of source address
  localparam logic [14:0] LFSR_SEED = 15'h7FFF; // scrambler start
  // ----------------------------------------
  // register map, byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00; // iso, secure, bus, resil
  localparam logic [7:0] A_EN     = 8'h04; // port enable
  localparam logic [7:0] A_TEST   = 8'h08; // port test pattern
  localparam logic [7:0] A_XOVER  = 8'h0C; // port crossover
  localparam logic [7:0] A_STAT   = 8'h10; // partition, jabber (ro)
  localparam logic [7:0] A_INTR   = 8'h14; // intruder flags (w1c)
  localparam logic [7:0] A_FRAMES = 8'h18; // repeated frames (ro)
  localparam logic [7:0] A_COLLS  = 8'h1C; // collisions (ro)
  localparam logic [7:0] A_ADDR   = 8'h40; // port address lo/hi pairs
  // ctrl field positions
  localparam int C_ISO = 0;
  localparam int C_SEC = 1;
  localparam int C_BUS = 2; // two bits
  localparam int C_RES = 4;
  localparam int STAT_JAB = 16; // jabber bits start here
  // ----------------------------------------
  // backplane carriers
  // ----------------------------------------
  typedef struct packed {
    logic crs; // carrier from the selected bus
    logic col; // collision signalled by the bus
    logic dat; // serial data
  } rpp_bp_in_t;
  typedef struct packed {
    logic backplane_bus_three;
    logic backplane_bus_two;
    logic backplane_bus_one;
    logic en;  // module drives the bus
    logic dat; // serial data
  } rpp_bp_out_t;
endpackage
`default_nettype wire

// ===== tb/rpp_bp_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// backplane bus stand-in: one of the three buses
// ------------------------------------------------
module rpp_bp_model #(
  parameter int BUS = 0 // bus this model sits on
) (
  // clock and scenario control
  input  wire logic                 clk_i,
  input  wire logic                 go_i,
  // module side
  input  wire rpp_pkg::rpp_bp_out_t bp_o_i,
  output rpp_pkg::rpp_bp_in_t       bp_i_o = '0,
  // cycles the module drove this bus
  output int                        seen_o = 0
);
  logic [2:0] sel_w; // one-hot bus pick
  assign sel_w = {bp_o_i.backplane_bus_three, bp_o_i.backplane_bus_two,
                  bp_o_i.backplane_bus_one};
  // carrier only reaches a module routed to this bus
  always_ff @(posedge clk_i) begin
    bp_i_o.crs <= go_i & sel_w[BUS];
    bp_i_o.col <= go_i & sel_w[BUS] & bp_o_i.en;
    // line toggles so a stale level never looks valid
    bp_i_o.dat <= ~bp_i_o.dat;
    if (bp_o_i.en & sel_w[BUS]) begin
      seen_o <= seen_o + 1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam logic [159:0] FRM = {56'h0, 48'h5678, 48'h1234, 8'hD5};
  logic                 clk_i;
  logic                 rst_i = 1'b1;
  logic                 wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic                 wb_ack, power_indicator, bp_go = 1'b0;
  logic [7:0]           wb_adr = 8'h00;
  logic [3:0]           wb_sel = 4'h0;
  logic [31:0]          wb_wdat = 32'h0, wb_rdat;
  logic [11:0]          rx_crs = '0, rx_dat = '0, rx_good = '0;
  logic [11:0]          link_ok = 12'hFFF, tx_en, tx_dat, xover;
  logic [159:0]         cap1, cap2;    // last bits sent on ports 1, 2
  logic                 strap_iso = 1'b0, strap_sec = 1'b0;
  logic [1:0]           strap_bus = 2'h0;
  logic [11:0]          strap_pwrdis = 12'h004, strap_xover = 12'h800;
  rpp_pkg::rpp_bp_in_t  bp_in;
  rpp_pkg::rpp_bp_out_t bp_out;
  int                   bp_seen, cnt2 = 0, s;
  int                   mismatches = 0, tests_run = 0;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // short jabber limit, still above the long collision test
  rpp_port_guard #(.JAB_CYCLES(1500), .PART_MAX(2000)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .rx_crs_i(rx_crs), .rx_dat_i(rx_dat), .rx_good_i(rx_good),
    .link_ok_i(link_ok), .tx_en_o(tx_en), .tx_dat_o(tx_dat),
    .xover_o(xover), .bp_i(bp_in), .bp_o(bp_out),
    .strap_iso_i(strap_iso), .strap_sec_i(strap_sec),
    .strap_bus_i(strap_bus), .strap_pwrdis_i(strap_pwrdis),
    .strap_xover_i(strap_xover), .power_indicator_o(power_indicator));
  rpp_bp_model #(.BUS(0)) bp_u (.clk_i(clk_i), .go_i(bp_go),
    .bp_o_i(bp_out), .bp_i_o(bp_in), .seen_o(bp_seen));
  // capture transmitted bits of two watched ports
  always @(posedge clk_i) begin
    if (tx_en[1]) cap1 <= {tx_dat[1], cap1[159:1]};
    if (tx_en[2]) cap2 <= {tx_dat[2], cap2[159:1]};
    if (tx_en[2]) cnt2 <= cnt2 + 1;
  end
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic complete_run;
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // classic cycle; wait for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    logic ok;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk_i);
      n++;
      ok = wb_ack;
    end while (ok !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (ok !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(e, q);
  endtask
  // frame on port p, look at port o's enable at bit k
  task automatic frame(int p, int o, logic e, int n, int k);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_crs[p] <= 1'b1;
      rx_dat[p] <= FRM[i % 160];
      if (i == k) begin
        #1 chk(e, tx_en[o]);
      end
    end
    @(posedge clk_i);
    rx_crs[p] <= 1'b0;
    rx_dat[p] <= ~rx_dat[p];
    repeat (4) @(posedge clk_i);
  endtask
  // n-bit collision of ports a and b, jam check if j
  task automatic coll(int a, int b, int n, bit j);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      {rx_crs[a], rx_crs[b]} <= 2'b11;
      {rx_dat[a], rx_dat[b]} <= {i[0], ~i[0]};
    end
    @(posedge clk_i);
    {rx_crs[a], rx_crs[b]} <= 2'b00;
    repeat (90) @(posedge clk_i);
    #1 if (j) chk(1, tx_en[7]);
    repeat (30) @(posedge clk_i);
    #1 if (j) chk(0, tx_en[7]);
  endtask
  task automatic pulse_good(input logic [11:0] m);
    @(posedge clk_i);
    rx_good <= m;
    @(posedge clk_i);
    rx_good <= '0;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic s_regs;
    rd(rpp_pkg::A_EN, 32'hFFB);
    chk(1, power_indicator);
    chk(12'h800, xover);
    wr(rpp_pkg::A_EN, 32'hFFF);
    rd(rpp_pkg::A_EN, 32'hFFF);
    wr(rpp_pkg::A_XOVER, 32'h001);
    chk(12'h001, xover);
    rd(8'h3C, 32'h0);
    wr(rpp_pkg::A_STAT, 32'hFFFF);
    rd(rpp_pkg::A_STAT, 32'h0);
  endtask
  task automatic s_repeat;
    frame(0, 1, 1, 160, 3);
    chk(1, cap1 === FRM);
    chk(160, bp_seen);
    rd(rpp_pkg::A_FRAMES, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(rpp_pkg::A_CTRL, c << 2);
      chk((c == 1) ? 2 : (c == 2) ? 4 : 1, bp_out[4:2]);
    end
    wr(rpp_pkg::A_CTRL, 32'h1);
    chk(0, bp_out[4:2]);
    s = bp_seen;
    frame(0, 1, 1, 160, 3);
    chk(s, bp_seen);
    rd(rpp_pkg::A_CTRL, 32'h1);
    wr(rpp_pkg::A_CTRL, 32'h0);
  endtask
  task automatic s_part;
    coll(0, 3, 4, 1);
    repeat (30) coll(0, 3, 4, 0);
    frame(0, 1, 1, 160, 3);
    frame(3, 1, 1, 160, 3);
    repeat (31) coll(0, 3, 4, 0);
    rd(rpp_pkg::A_STAT, 32'h0);
    coll(0, 3, 4, 0);
    rd(rpp_pkg::A_STAT, 32'h9);
    frame(0, 1, 0, 160, 3);
    bp_go <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(1, tx_en[0]);
    bp_go <= 1'b0;
    repeat (8) @(posedge clk_i);
    pulse_good(12'h009);
    rd(rpp_pkg::A_STAT, 32'h0);
    coll(5, 6, 1100, 0);
    rd(rpp_pkg::A_STAT, 32'h60);
    pulse_good(12'h060);
    rd(rpp_pkg::A_STAT, 32'h0);
    frame(0, 9, 0, 1700, 1600);
  endtask
  // straps are taken again after a mid-run reset
  task automatic s_strap;
    @(posedge clk_i);
    {strap_iso, strap_sec, strap_bus} <= 4'hE;
    {strap_pwrdis, strap_xover} <= {12'h0F0, 12'h00A};
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(rpp_pkg::A_CTRL, 32'hB);
    rd(rpp_pkg::A_EN, 32'hF0F);
    chk(12'h00A, xover);
    chk(0, bp_out[4:2]);
    wr(rpp_pkg::A_TEST, 32'h2);
    @(posedge clk_i);
    #1 chk(1, tx_en[1]);
  endtask
  task automatic s_secure;
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h1234);
    wr(8'h4C, 32'h0);
    wr(rpp_pkg::A_CTRL, 32'h2);
    s = cnt2;
    frame(0, 1, 1, 160, 3);
    chk(1, cap1 === FRM);
    chk(1, cap2[55:0] === FRM[55:0]);
    chk(1, cap2[159:104] !== FRM[159:104]);
    chk(160, cnt2 - s);
    rd(rpp_pkg::A_INTR, 32'h1);
    wr(rpp_pkg::A_INTR, 32'h1);
    rd(rpp_pkg::A_INTR, 32'h0);
    wr(rpp_pkg::A_CTRL, 32'h10);
    wr(rpp_pkg::A_EN, 32'hFFD);
    link_ok[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(rpp_pkg::A_EN, 32'hFFE);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs();
    s_repeat();
    s_part();
    s_secure();
    s_strap();
    complete_run();
  end
endmodule
`default_nettype wire
